// *** sers_pkg.sv ***
// Constants for the two-wire EEPROM read sequencer
//
// Contract
// - On a matching read device word the device acknowledges and shifts out the addressed byte MSB first.
// - Sequential reads start from either read kind and continue only on the host's acknowledge.
// - After each byte sent the device increments the address; on a host acknowledge it sends the next byte in eight clocks.
// - In a sequential read the address wraps from the top location to zero without a break.
// - A not-acknowledge followed by stop ends the read; the device releases data and goes idle.
// - The eighth bit of the device word is the direction: high reads, low writes.
// - The address counter holds last address plus one between operations; current reads start there.
// - Read addressing wraps over the whole array, from the last byte to the first.
// - The device acknowledges each received word by pulling data low in the ninth clock; the code acknowledges only a matching device word and the word address.
package sers_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 2048;
    localparam logic [3:0] DEV_TYPE = 4'ha;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
    localparam int BUF_DEPTH = 2;
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_DEV = 3'h1,
        ST_DEV_ACK = 3'h2,
        ST_WADDR = 3'h3,
        ST_WADDR_ACK = 3'h4,
        ST_RD = 3'h5,
        ST_RD_ACK = 3'h6,
        ST_IGNORE = 3'h7
    } sers_state_e;
endpackage

// *** sers_buf.sv ***
// Two-entry valid/ready buffer
`timescale 1ns/1ps
`default_nettype none
module sers_buf
    import sers_pkg::*;
#(
    parameter int WIDTH = DATA_W
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    logic [WIDTH-1:0] mem [BUF_DEPTH];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    wire push = i_valid && (count != 2'h2);
    wire pop = i_ready && (count != 2'h0);
    assign o_ready = (count != 2'h2);
    assign o_valid = (count != 2'h0);
    assign o_data = mem[rd_ptr];
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
            mem[0] <= '0;
            mem[1] <= '0;
        end
        else
        begin
            if (push)
            begin
                mem[wr_ptr] <= i_data;
                wr_ptr <= ~wr_ptr;
            end
            if (pop)
                rd_ptr <= ~rd_ptr;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

// *** sers_top.sv ***
// Two-wire EEPROM target, read protocol sequencer
`timescale 1ns/1ps
`default_nettype none
module sers_top
    import sers_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    output logic [ADDR_W-1:0] o_mem_addr,
    output logic o_mem_rd,
    input wire logic [DATA_W-1:0] i_mem_data,
    input wire logic i_mem_valid,
    output logic o_mem_ready,
    output logic o_busy
);
    // ------------------------------------------------------------
    // Pin synchronisers and edge detect
    // ------------------------------------------------------------
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_m <= i_scl;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= i_sda;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end
    wire scl_rise = scl_s && !scl_d;
    wire scl_fall = !scl_s && scl_d;
    wire start_cond = scl_s && scl_d && sda_d && !sda_s;
    wire stop_cond = scl_s && scl_d && !sda_d && sda_s;

    // ------------------------------------------------------------
    // Read data path through the buffer
    // ------------------------------------------------------------
    logic buf_valid;
    logic buf_ready;
    logic [DATA_W-1:0] buf_data;
    logic buf_take;
    sers_buf #(
        .WIDTH(DATA_W)
    ) u_buf (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_valid(i_mem_valid),
        .o_ready(buf_ready),
        .i_data(i_mem_data),
        .o_valid(buf_valid),
        .i_ready(buf_take),
        .o_data(buf_data)
    );

    // ------------------------------------------------------------
    // Protocol state
    // ------------------------------------------------------------
    sers_state_e state;
    logic [2:0] bit_cnt;
    logic [DATA_W-1:0] shift;
    logic [ADDR_W-1:0] addr;
    logic rd_pend;
    logic host_ack;
    logic [ADDR_W-DATA_W-1:0] page;
    wire last_bit = (bit_cnt == BIT_LAST);
    wire [DATA_W-1:0] rx_byte = {shift[DATA_W-2:0], sda_s};
    wire dev_match = (shift[DATA_W-2:DATA_W-5] == DEV_TYPE);
    wire dev_read = sda_s;
    wire in_read = (state == ST_RD) || (state == ST_RD_ACK);
    // Byte taken at the end of the ack slot; a declined prefetch is dropped
    wire load_byte = scl_fall && ((state == ST_DEV_ACK && rd_pend && o_sda_oe) || state == ST_RD_ACK);
    assign buf_take = load_byte && buf_valid;
    wire [ADDR_W-1:0] addr_inc = addr + 11'h001;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state <= ST_IDLE;
            bit_cnt <= 3'h0;
            shift <= '0;
            addr <= ADDR_RST;
            rd_pend <= 1'b0;
            host_ack <= 1'b0;
            page <= '0;
            o_sda <= 1'b1;
            o_sda_oe <= 1'b0;
            o_mem_rd <= 1'b0;
            o_mem_addr <= ADDR_RST;
            o_mem_ready <= 1'b0;
            o_busy <= 1'b0;
        end
        else
        begin
            o_mem_rd <= 1'b0;
            o_mem_ready <= buf_ready;
            o_mem_addr <= addr;
            o_busy <= (state != ST_IDLE);
            if (stop_cond)
            begin
                state <= ST_IDLE;
                o_sda_oe <= 1'b0;
            end
            else if (start_cond)
            begin
                // Repeated start re-enters addressing
                state <= ST_DEV;
                bit_cnt <= 3'h0;
                o_sda_oe <= 1'b0;
            end
            else
            begin
                case (state)
                    ST_IDLE, ST_IGNORE:
                        o_sda_oe <= 1'b0;
                    ST_DEV, ST_WADDR:
                        if (scl_rise)
                        begin
                            shift <= rx_byte;
                            bit_cnt <= bit_cnt + 3'h1;
                            if (last_bit && state == ST_DEV)
                            begin
                                if (dev_match)
                                begin
                                    state <= ST_DEV_ACK;
                                    rd_pend <= dev_read;
                                    // Page bits become the address MSBs
                                    page <= shift[ADDR_W-DATA_W-1:0];
                                    if (dev_read)
                                        o_mem_rd <= 1'b1;
                                end
                                else
                                    state <= ST_IGNORE;
                            end
                            else if (last_bit)
                            begin
                                // Low bits loaded; dummy write carries no data
                                addr <= {page, rx_byte};
                                state <= ST_WADDR_ACK;
                            end
                        end
                        else if (scl_fall && bit_cnt == 3'h0 && o_sda_oe)
                            o_sda_oe <= 1'b0;
                    ST_DEV_ACK, ST_WADDR_ACK:
                        if (scl_fall && !o_sda_oe)
                        begin
                            o_sda <= 1'b0;
                            o_sda_oe <= 1'b1;
                        end
                        else if (scl_fall)
                        begin
                            bit_cnt <= 3'h0;
                            if (state == ST_DEV_ACK && rd_pend)
                            begin
                                shift <= buf_data;
                                o_sda <= buf_data[DATA_W-1];
                                o_sda_oe <= !buf_data[DATA_W-1];
                                state <= ST_RD;
                            end
                            else
                            begin
                                o_sda_oe <= 1'b0;
                                state <= (state == ST_DEV_ACK) ? ST_WADDR : ST_IGNORE;
                            end
                        end
                    ST_RD:
                        if (scl_fall)
                        begin
                            bit_cnt <= bit_cnt + 3'h1;
                            if (last_bit)
                            begin
                                o_sda_oe <= 1'b0;
                                addr <= addr_inc;
                                o_mem_rd <= 1'b1;
                                state <= ST_RD_ACK;
                            end
                            else
                            begin
                                shift <= {shift[DATA_W-2:0], 1'b0};
                                o_sda <= shift[DATA_W-2];
                                o_sda_oe <= !shift[DATA_W-2];
                            end
                        end
                    ST_RD_ACK:
                        if (scl_rise)
                            host_ack <= !sda_s;
                        else if (scl_fall)
                        begin
                            bit_cnt <= 3'h0;
                            if (host_ack)
                            begin
                                shift <= buf_data;
                                o_sda <= buf_data[DATA_W-1];
                                o_sda_oe <= !buf_data[DATA_W-1];
                                state <= ST_RD;
                            end
                            else
                                state <= ST_IGNORE;
                        end
                    default:
                        state <= ST_IDLE;
                endcase
            end
            if (state == ST_DEV_ACK && rd_pend && in_read == 1'b0 && o_mem_rd)
                addr <= addr;
        end
    end
endmodule
`default_nettype wire

// *** sers_chk_assertions.sv ***
// Port-level checks for the read sequencer
`timescale 1ns/1ps
`default_nettype none
module sers_chk
    import sers_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda,
    input wire logic o_sda_oe,
    input wire logic [ADDR_W-1:0] o_mem_addr,
    input wire logic o_mem_rd,
    input wire logic o_busy
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence bus_start; i_scl && $past(i_scl) && $fell(i_sda); endsequence
    sequence bus_stop; i_scl && $past(i_scl) && $rose(i_sda); endsequence
    chk_busy_on_start: assert property (bus_start |-> ##[1:8] o_busy)
        else $error("no busy after start");
    chk_stop_to_idle: assert property (bus_stop |-> ##[1:8] !o_busy)
        else $error("busy after stop");
    chk_idle_no_drive: assert property (!o_busy |-> !o_sda_oe)
        else $error("drive while idle");
    chk_oe_stable_high: assert property (i_scl [*4] |-> $stable(o_sda_oe))
        else $error("data moved in high");
    chk_oe_change_low: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("data moved at high");
    chk_fetch_single: assert property (o_mem_rd |=> !o_mem_rd)
        else $error("fetch pulse too long");
    chk_fetch_busy: assert property (o_mem_rd |-> o_busy)
        else $error("fetch while idle");
    chk_addr_hold_idle: assert property (!o_busy && !$past(o_busy) |-> $stable(o_mem_addr))
        else $error("addr moved");
    chk_drive_only_low: assert property (o_sda_oe |-> !o_sda)
        else $error("drive with high data");
endmodule
bind sers_top sers_chk sers_chk_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_busy(o_busy));
`default_nettype wire

// *** sers_host.sv ***
// Bus host model: drives the two-wire clock and pulls data low
`timescale 1ns/1ps
`default_nettype none
module sers_host
(
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    initial
    begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // One clock, data set mid-low, sampled mid-high
    task automatic pulse(input logic b, output logic s);
        o_sda_low = ~b;
        #12 o_scl = 1'b1;
        #12 s = i_sda;
        #12 o_scl = 1'b0;
        #12;
    endtask
    task automatic start();
        o_sda_low = 1'b0;
        #12 o_scl = 1'b1;
        #24 o_sda_low = 1'b1;
        #24 o_scl = 1'b0;
        #12;
    endtask
    task automatic stop();
        o_sda_low = 1'b1;
        #12 o_scl = 1'b1;
        #24 o_sda_low = 1'b0;
        #24;
    endtask
    task automatic send(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            pulse(v[i], s);
        pulse(1'b1, ack);
    endtask
    task automatic recv(input logic more, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--)
            pulse(1'b1, v[i]);
        pulse(~more, s);
    endtask
endmodule
`default_nettype wire

// *** sers_top_bench.sv ***
// Self-checking bench for the read sequencer
`timescale 1ns/1ps
`default_nettype none
module sers_top_bench;
    import sers_pkg::*;
    typedef struct {logic rnd; logic [ADDR_W-1:0] addr; int n;} sers_row_s;
    sers_row_s rows [5] = '{'{1'b1, 11'h000, 1}, '{1'b1, 11'h123, 3}, '{1'b1, 11'h7fe, 4},
        '{1'b0, 11'h002, 2}, '{1'b1, 11'h0a5, 2}};
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic mem_valid = 1'b0;
    logic [DATA_W-1:0] mem_data = 8'h00;
    logic rd_seen = 1'b0;
    logic ready_seen = 1'b0;
    logic ack;
    logic [DATA_W-1:0] got;
    logic [ADDR_W-1:0] exp;
    int num_errors = 0;
    int checks_done = 0;
    wire logic scl, host_low, sda_oe, mem_rd, mem_ready, busy;
    wire logic [ADDR_W-1:0] mem_addr;
    wire logic sda_line = ~(sda_oe | host_low);
    sers_host sers_host_inst (.i_sda(sda_line), .o_scl(scl), .o_sda_low(host_low));
    sers_top sers_top_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda_line), .o_sda(),
        .o_sda_oe(sda_oe), .o_mem_addr(mem_addr), .o_mem_rd(mem_rd), .i_mem_data(mem_data),
        .i_mem_valid(mem_valid), .o_mem_ready(mem_ready), .o_busy(busy));
    initial
    begin
        forever #2.5 i_clk = ~i_clk;
    end
    // Array contents derived from the address
    function automatic logic [7:0] mem_byte(input logic [ADDR_W-1:0] a);
        return a[7:0] ^ {a[10:8], 5'h15};
    endfunction
    // Memory: answers a fetch one cycle later, holds until taken
    always @(posedge i_clk)
    begin
        #1;
        if (mem_valid && ready_seen)
            mem_valid = 1'b0;
        if (rd_seen)
        begin
            mem_data = mem_byte(mem_addr);
            mem_valid = 1'b1;
        end
        rd_seen = mem_rd;
        ready_seen = mem_ready;
    end
    task automatic check_value(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic complete_run();
        if (num_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic finish_read();
        sers_host_inst.stop();
        repeat (10) @(posedge i_clk);
        check_value(busy, 1'b0);
        check_value(sda_oe, 1'b0);
        check_value(mem_addr, exp);
    endtask
    initial
    begin
        #200000;
        num_errors++;
        complete_run();
    end
    initial
    begin
        repeat (6) @(posedge i_clk);
        check_value(mem_addr, 11'h000);
        #1 i_rst_n = 1'b1;
        repeat (4) @(posedge i_clk);
        check_value(mem_ready, 1'b1);
        foreach (rows[r])
        begin
            exp = rows[r].addr;
            if (rows[r].rnd)
            begin
                sers_host_inst.start();
                sers_host_inst.send({DEV_TYPE, exp[10:8], 1'b0}, ack);
                check_value(ack, 1'b0);
                sers_host_inst.send(exp[7:0], ack);
                check_value(ack, 1'b0);
            end
            sers_host_inst.start();
            sers_host_inst.send({DEV_TYPE, exp[10:8], 1'b1}, ack);
            check_value(ack, 1'b0);
            for (int i = 0; i < rows[r].n; i++)
            begin
                sers_host_inst.recv(i < rows[r].n - 1, got);
                check_value(got, mem_byte(exp));
                exp = exp + 1'b1;
            end
            finish_read();
        end
        // Foreign device type: no acknowledge, nothing moves
        sers_host_inst.start();
        sers_host_inst.send({4'hb, 3'h0, 1'b1}, ack);
        check_value(ack, 1'b1);
        finish_read();
        // Stop straight after an acknowledged byte
        // Next byte opens with a one, so the line is free for the stop
        sers_host_inst.start();
        sers_host_inst.send({DEV_TYPE, 3'h0, 1'b1}, ack);
        check_value(ack, 1'b0);
        sers_host_inst.recv(1'b1, got);
        check_value(got, mem_byte(exp));
        exp = exp + 1'b1;
        finish_read();
        // Reset in mid-run clears the counter
        #1 i_rst_n = 1'b0;
        repeat (2) @(posedge i_clk);
        check_value(mem_addr, ADDR_RST);
        check_value(busy, 1'b0);
        #1 i_rst_n = 1'b1;
        repeat (4) @(posedge i_clk);
        exp = ADDR_RST;
        sers_host_inst.start();
        sers_host_inst.send({DEV_TYPE, exp[10:8], 1'b1}, ack);
        check_value(ack, 1'b0);
        sers_host_inst.recv(1'b0, got);
        check_value(got, mem_byte(exp));
        exp = exp + 1'b1;
        finish_read();
        complete_run();
    end
endmodule
`default_nettype wire
